// [core/dcl_pkg.sv]
/*
 * Constants, register map and state codes of the data cache line controller.
 * Assumes a 32-bit core address, 16-byte lines and four ways per set.
 */
`default_nettype none
package dcl_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int WAYS = 4;
    localparam int WAY_W = 2;
    localparam int WORDS = 4;
    localparam int LINE_W = 128;
    localparam int OFS_W = 4;
    localparam int WSEL_LSB = 2;
    localparam int WSEL_W = 2;
    localparam int APB_DEC_W = 8;
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_REGION0 = 8'h04;
    localparam logic [7:0] OFS_REGION1 = 8'h08;
    localparam logic [7:0] OFS_PUSH = 8'h0c;
    localparam logic [7:0] OFS_PUSH_BOTH = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    // Control register fields
    localparam int CTL_ENABLE = 31;
    localparam int CTL_KEEP_DATA = 28;
    localparam int CTL_FLUSH_ALL = 24;
    localparam int CTL_IVO = 20;
    localparam int CTL_SPA = 14;
    localparam int CTL_KEEP_INSTR = 12;
    localparam int CTL_DEF_POLICY = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK = 32'h9010_5100;
    // Region register fields
    localparam int RGN_BASE_LSB = 24;
    localparam int RGN_MASK_LSB = 16;
    localparam int RGN_FIELD_W = 8;
    localparam int RGN_EN = 15;
    localparam int RGN_POLICY = 5;
    localparam logic [31:0] RGN_RESET = 32'h0000_0000;
    localparam logic POLICY_WTHRU = 1'b1;
    // Push operand fields (direct set/way)
    localparam int PUSH_SET_LSB = 4;
    localparam int PUSH_WAY_LSB = 0;
    // Status fields
    localparam int STS_BUSY = 0;
    localparam int STS_PUSH_PEND = 1;
    localparam int STS_PBUF_FULL = 2;
    localparam int STS_LAST_HIT = 3;
    localparam int STS_FLUSH_PEND = 4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FILL = 3'b001,
        ST_WB = 3'b010,
        ST_WT = 3'b011,
        ST_PUSH = 3'b100
    } dcl_state_t;
endpackage
`default_nettype wire

// [core/dcl_line_ctrl.sv]
/*
 * Data cache line state control: lookup, allocation, victim push buffer,
 * write-through and copyback handling, line push and invalidate operations.
 * Assumes core and memory ports run on clk_sys; APB slave for control.
 */
// The placing of the registers and register access over APB are this design's own decisions.
// Overview of operation
// - Each line keeps valid and modified flags.
// - Policy from matching region, else default.
// - Miss fills an invalid way first.
// - Full set: pseudo round robin victim.
// - Modified victim buffered, written after fill.
// - Read miss fills line, returns data, valid.
// - Modified victim: fill, supply, write back.
// - Read hit leaves line state unchanged.
// - Copyback write miss allocates, merges, modified.
// - Copyback write hit marks line modified.
// - Write-through miss writes memory, no allocate.
// - Write-through hit writes both, line valid.
// - Write-through miss leaves stale modified line.
// - Invalidate drops lines without write back.
// - Push writes modified line, then clear/keep.
// - Control bit 14 selects address search.
// - Control bit 20 makes push invalidate only.
// - Bits 28/12 pick data/instruction push action.
// - Operand is set/way or physical address.
// - Address push touches only matching line.
// - Reset clears control, keeps cache arrays.
`timescale 1ns/1ps
`default_nettype none
module dcl_line_ctrl #(
    parameter int SET_W = 7
) (
    input wire logic clk_sys, // Core clock
    input wire logic srst, // Synchronous reset
    input wire logic [31:0] paddr, // APB address
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic cpu_req, // Core access request
    input wire logic cpu_we, // Core write
    input wire logic [31:0] cpu_addr, // Core byte address
    input wire logic [31:0] cpu_wdata, // Core write word
    output logic cpu_ready, // Request taken this cycle
    output logic cpu_ack, // Access done pulse
    output logic [31:0] cpu_rdata, // Read word
    output logic mem_req, // Memory request level
    output logic mem_we, // Memory write
    output logic [31:0] mem_addr, // Line address; core byte address for write-through
    output logic [dcl_pkg::LINE_W-1:0] mem_wdata, // Line write data
    output logic [dcl_pkg::WORDS-1:0] mem_wmask, // Word enables
    input wire logic mem_ack, // Memory done pulse
    input wire logic [dcl_pkg::LINE_W-1:0] mem_rdata, // Fetched line
    output logic icache_clear, // Instruction line clear pulse
    output logic [31:0] icache_addr // Operand for instruction side
);
    localparam int SETS = 1 << SET_W;
    localparam int TAG_W = dcl_pkg::ADDR_W - SET_W - dcl_pkg::OFS_W;

    logic [TAG_W-1:0] tag_r [SETS][dcl_pkg::WAYS];
    logic [dcl_pkg::LINE_W-1:0] data_r [SETS][dcl_pkg::WAYS];
    logic [dcl_pkg::WAYS-1:0] valid_r [SETS];
    logic [dcl_pkg::WAYS-1:0] mod_r [SETS];
    logic [31:0] ctrl_r, rgn0_r, rgn1_r, push_op_r, prdata_r, req_addr_r, req_wdata_r;
    logic [31:0] mem_addr_r, cpu_rdata_r, icache_addr_r;
    logic [dcl_pkg::LINE_W-1:0] mem_wdata_r, pbuf_r;
    logic [dcl_pkg::WORDS-1:0] mem_wmask_r;
    logic [31:0] pbuf_addr_r;
    logic pslverr_r, flush_pend_r, push_pend_r, push_instr_r, pbuf_full_r;
    logic req_we_r, alloc_r, cpu_ack_r, icache_clear_r, last_hit_r;
    logic [dcl_pkg::WAY_W-1:0] rr_r, fill_way_r, tgt_way_r, vic_way;
    logic [SET_W-1:0] fill_set_r, tgt_set_r;
    logic vic_free;
    dcl_pkg::dcl_state_t state_r;

    function automatic logic [31:0] word_of(input logic [dcl_pkg::LINE_W-1:0] line,
                                           input logic [31:0] a);
        return line[a[dcl_pkg::WSEL_LSB +: dcl_pkg::WSEL_W] * dcl_pkg::DATA_W +: dcl_pkg::DATA_W];
    endfunction

    function automatic logic [dcl_pkg::LINE_W-1:0] merge(input logic [dcl_pkg::LINE_W-1:0] line,
                                                         input logic [31:0] a,
                                                         input logic [31:0] d);
        logic [dcl_pkg::LINE_W-1:0] r;
        r = line;
        r[a[dcl_pkg::WSEL_LSB +: dcl_pkg::WSEL_W] * dcl_pkg::DATA_W +: dcl_pkg::DATA_W] = d;
        return r;
    endfunction

    function automatic logic [dcl_pkg::WORDS-1:0] word_mask(input logic [31:0] a);
        return dcl_pkg::WORDS'(1) << a[dcl_pkg::WSEL_LSB +: dcl_pkg::WSEL_W];
    endfunction

    function automatic logic [SET_W-1:0] set_of(input logic [31:0] a);
        return a[dcl_pkg::OFS_W +: SET_W];
    endfunction

    function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] a);
        return a[dcl_pkg::ADDR_W-1 -: TAG_W];
    endfunction

    // Returns {hit, way}; any valid line with a matching tag counts as present, modified or not
    function automatic logic [dcl_pkg::WAY_W:0] find_way(input logic [31:0] a);
        logic [dcl_pkg::WAY_W:0] r;
        r = '0;
        for (int w = 0; w < dcl_pkg::WAYS; w++)
        begin
            if (valid_r[set_of(a)][w] && tag_r[set_of(a)][w] == tag_of(a))
                r = {1'b1, dcl_pkg::WAY_W'(w)};
        end
        return r;
    endfunction

    function automatic logic region_hit(input logic [31:0] rg, input logic [31:0] a);
        return rg[dcl_pkg::RGN_EN] &&
            (((a[dcl_pkg::RGN_BASE_LSB +: dcl_pkg::RGN_FIELD_W] ^
               rg[dcl_pkg::RGN_BASE_LSB +: dcl_pkg::RGN_FIELD_W]) &
              ~rg[dcl_pkg::RGN_MASK_LSB +: dcl_pkg::RGN_FIELD_W]) == '0);
    endfunction

    // Core-side lookup
    logic [dcl_pkg::WAY_W:0] c_find;
    logic [SET_W-1:0] c_set;
    logic c_hit, c_wt, c_en, accept;
    // Comb blocks, not assigns: the array reads inside the function must wake the lookup
    always_comb c_find = find_way(cpu_addr);
    assign c_set = set_of(cpu_addr);
    assign c_en = ctrl_r[dcl_pkg::CTL_ENABLE];
    assign c_hit = c_en && c_find[dcl_pkg::WAY_W];
    // Region 0 wins over region 1 when both match
    assign c_wt = region_hit(rgn0_r, cpu_addr) ? rgn0_r[dcl_pkg::RGN_POLICY] :
                  region_hit(rgn1_r, cpu_addr) ? rgn1_r[dcl_pkg::RGN_POLICY] :
                  ctrl_r[dcl_pkg::CTL_DEF_POLICY];
    // Maintenance first, so a queued push sees a quiet array
    assign cpu_ready = state_r == dcl_pkg::ST_IDLE && !flush_pend_r && !push_pend_r;
    assign accept = cpu_req && cpu_ready;

    always_comb
    begin
        vic_way = rr_r;
        vic_free = 1'b0;
        for (int w = dcl_pkg::WAYS - 1; w >= 0; w--)
        begin
            if (!valid_r[c_set][w])
            begin
                vic_way = dcl_pkg::WAY_W'(w);
                vic_free = 1'b1;
            end
        end
    end

    // Push target: physical search or direct set/way
    logic [dcl_pkg::WAY_W:0] p_find;
    logic [SET_W-1:0] p_set;
    logic [dcl_pkg::WAY_W-1:0] p_way;
    logic p_hit, p_val, p_mod;
    always_comb p_find = find_way(push_op_r);
    assign p_set = ctrl_r[dcl_pkg::CTL_SPA] ? set_of(push_op_r) :
                   push_op_r[dcl_pkg::PUSH_SET_LSB +: SET_W];
    assign p_way = ctrl_r[dcl_pkg::CTL_SPA] ? p_find[dcl_pkg::WAY_W-1:0] :
                   push_op_r[dcl_pkg::PUSH_WAY_LSB +: dcl_pkg::WAY_W];
    assign p_hit = ctrl_r[dcl_pkg::CTL_SPA] ? p_find[dcl_pkg::WAY_W] : 1'b1;
    assign p_val = p_hit && valid_r[p_set][p_way];
    assign p_mod = p_val && mod_r[p_set][p_way];

    // APB slave
    logic [7:0] a_ofs;
    logic wr_acc, push_wr;
    assign a_ofs = paddr[dcl_pkg::APB_DEC_W-1:0];
    assign push_wr = a_ofs == dcl_pkg::OFS_PUSH || a_ofs == dcl_pkg::OFS_PUSH_BOTH;
    // A second push waits in the access phase until the first one starts
    assign pready = !(psel && penable && pwrite && push_wr && push_pend_r);
    assign wr_acc = psel && penable && pwrite && pready;

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            prdata_r <= '0;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr_r <= 1'b0;
            unique case (a_ofs)
                dcl_pkg::OFS_CTRL: prdata_r <= ctrl_r;
                dcl_pkg::OFS_REGION0: prdata_r <= rgn0_r;
                dcl_pkg::OFS_REGION1: prdata_r <= rgn1_r;
                dcl_pkg::OFS_PUSH, dcl_pkg::OFS_PUSH_BOTH: prdata_r <= push_op_r;
                dcl_pkg::OFS_STATUS:
                begin
                    prdata_r <= '0;
                    prdata_r[dcl_pkg::STS_BUSY] <= state_r != dcl_pkg::ST_IDLE;
                    prdata_r[dcl_pkg::STS_PUSH_PEND] <= push_pend_r;
                    prdata_r[dcl_pkg::STS_PBUF_FULL] <= pbuf_full_r;
                    prdata_r[dcl_pkg::STS_LAST_HIT] <= last_hit_r;
                    prdata_r[dcl_pkg::STS_FLUSH_PEND] <= flush_pend_r;
                end
                default:
                begin
                    prdata_r <= '0;
                    pslverr_r <= 1'b1;
                end
            endcase
        end
    end

    // Reset clears only control state; tags, flags and data are left alone
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ctrl_r <= dcl_pkg::CTRL_RESET;
            rgn0_r <= dcl_pkg::RGN_RESET;
            rgn1_r <= dcl_pkg::RGN_RESET;
            push_op_r <= '0;
        end
        else if (wr_acc)
        begin
            unique case (a_ofs)
                dcl_pkg::OFS_CTRL: ctrl_r <= pwdata & dcl_pkg::CTRL_WMASK;
                dcl_pkg::OFS_REGION0: rgn0_r <= pwdata;
                dcl_pkg::OFS_REGION1: rgn1_r <= pwdata;
                dcl_pkg::OFS_PUSH, dcl_pkg::OFS_PUSH_BOTH: push_op_r <= pwdata;
                default: ;
            endcase
        end
    end

    // Request flags: a new request in the clearing cycle wins
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            flush_pend_r <= 1'b0;
            push_pend_r <= 1'b0;
            push_instr_r <= 1'b0;
        end
        else
        begin
            if (wr_acc && a_ofs == dcl_pkg::OFS_CTRL && pwdata[dcl_pkg::CTL_FLUSH_ALL])
                flush_pend_r <= 1'b1;
            else if (state_r == dcl_pkg::ST_IDLE)
                flush_pend_r <= 1'b0;
            if (wr_acc && push_wr)
            begin
                push_pend_r <= 1'b1;
                push_instr_r <= a_ofs == dcl_pkg::OFS_PUSH_BOTH;
            end
            else if (state_r == dcl_pkg::ST_IDLE && !flush_pend_r)
                push_pend_r <= 1'b0;
        end
    end

    // Line state machine and arrays
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r <= dcl_pkg::ST_IDLE;
            rr_r <= '0;
            pbuf_full_r <= 1'b0;
            cpu_ack_r <= 1'b0;
            cpu_rdata_r <= '0;
            mem_addr_r <= '0;
            mem_wdata_r <= '0;
            mem_wmask_r <= '0;
            icache_clear_r <= 1'b0;
            icache_addr_r <= '0;
            last_hit_r <= 1'b0;
            alloc_r <= 1'b0;
        end
        else
        begin
            cpu_ack_r <= 1'b0;
            icache_clear_r <= 1'b0;
            unique case (state_r)
                dcl_pkg::ST_IDLE:
                begin
                    if (flush_pend_r)
                    begin
                        for (int s = 0; s < SETS; s++)
                            valid_r[s] <= '0;
                    end
                    else if (push_pend_r)
                    begin
                        last_hit_r <= p_val;
                        tgt_set_r <= p_set;
                        tgt_way_r <= p_way;
                        icache_addr_r <= push_op_r;
                        icache_clear_r <= push_instr_r && (ctrl_r[dcl_pkg::CTL_IVO] ||
                                          !ctrl_r[dcl_pkg::CTL_KEEP_INSTR]);
                        if (ctrl_r[dcl_pkg::CTL_IVO])
                        begin
                            if (p_hit)
                                valid_r[p_set][p_way] <= 1'b0;
                        end
                        else if (p_mod)
                        begin
                            mem_addr_r <= {tag_r[p_set][p_way], p_set, dcl_pkg::OFS_W'(0)};
                            mem_wdata_r <= data_r[p_set][p_way];
                            mem_wmask_r <= '1;
                            state_r <= dcl_pkg::ST_PUSH;
                        end
                        else if (p_val && !ctrl_r[dcl_pkg::CTL_KEEP_DATA])
                            valid_r[p_set][p_way] <= 1'b0;
                    end
                    else if (accept)
                    begin
                        req_addr_r <= cpu_addr;
                        req_we_r <= cpu_we;
                        req_wdata_r <= cpu_wdata;
                        if (c_hit && !cpu_we)
                        begin
                            cpu_rdata_r <= word_of(data_r[c_set][c_find[1:0]], cpu_addr);
                            cpu_ack_r <= 1'b1;
                        end
                        else if (c_hit)
                        begin
                            data_r[c_set][c_find[1:0]] <=
                                merge(data_r[c_set][c_find[1:0]], cpu_addr, cpu_wdata);
                            mod_r[c_set][c_find[1:0]] <= !c_wt;
                            if (c_wt)
                            begin
                                mem_addr_r <= cpu_addr;
                                mem_wdata_r <= merge('0, cpu_addr, cpu_wdata);
                                mem_wmask_r <= word_mask(cpu_addr);
                                state_r <= dcl_pkg::ST_WT;
                            end
                            else
                                cpu_ack_r <= 1'b1;
                        end
                        else if (cpu_we && (c_wt || !c_en))
                        begin
                            mem_addr_r <= cpu_addr;
                            mem_wdata_r <= merge('0, cpu_addr, cpu_wdata);
                            mem_wmask_r <= word_mask(cpu_addr);
                            state_r <= dcl_pkg::ST_WT;
                        end
                        else
                        begin
                            alloc_r <= c_en;
                            fill_set_r <= c_set;
                            fill_way_r <= vic_way;
                            mem_addr_r <= {cpu_addr[31:dcl_pkg::OFS_W], dcl_pkg::OFS_W'(0)};
                            state_r <= dcl_pkg::ST_FILL;
                            if (c_en && !vic_free)
                                rr_r <= rr_r + 1'b1;
                            if (c_en && valid_r[c_set][vic_way] && mod_r[c_set][vic_way])
                            begin
                                pbuf_r <= data_r[c_set][vic_way];
                                pbuf_addr_r <= {tag_r[c_set][vic_way], c_set, dcl_pkg::OFS_W'(0)};
                                pbuf_full_r <= 1'b1;
                            end
                        end
                    end
                end
                dcl_pkg::ST_FILL:
                begin
                    if (mem_ack)
                    begin
                        if (alloc_r)
                        begin
                            tag_r[fill_set_r][fill_way_r] <= tag_of(req_addr_r);
                            data_r[fill_set_r][fill_way_r] <= req_we_r ?
                                merge(mem_rdata, req_addr_r, req_wdata_r) : mem_rdata;
                            valid_r[fill_set_r][fill_way_r] <= 1'b1;
                            mod_r[fill_set_r][fill_way_r] <= req_we_r;
                        end
                        cpu_rdata_r <= word_of(mem_rdata, req_addr_r);
                        cpu_ack_r <= 1'b1;
                        if (pbuf_full_r)
                        begin
                            mem_addr_r <= pbuf_addr_r;
                            mem_wdata_r <= pbuf_r;
                            mem_wmask_r <= '1;
                            state_r <= dcl_pkg::ST_WB;
                        end
                        else
                            state_r <= dcl_pkg::ST_IDLE;
                    end
                end
                dcl_pkg::ST_WB:
                begin
                    if (mem_ack)
                    begin
                        pbuf_full_r <= 1'b0;
                        state_r <= dcl_pkg::ST_IDLE;
                    end
                end
                dcl_pkg::ST_WT:
                begin
                    if (mem_ack)
                    begin
                        cpu_ack_r <= 1'b1;
                        state_r <= dcl_pkg::ST_IDLE;
                    end
                end
                dcl_pkg::ST_PUSH:
                begin
                    if (mem_ack)
                    begin
                        mod_r[tgt_set_r][tgt_way_r] <= 1'b0;
                        valid_r[tgt_set_r][tgt_way_r] <= ctrl_r[dcl_pkg::CTL_KEEP_DATA];
                        state_r <= dcl_pkg::ST_IDLE;
                    end
                end
                default: state_r <= dcl_pkg::ST_IDLE;
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign cpu_ack = cpu_ack_r;
    assign cpu_rdata = cpu_rdata_r;
    assign mem_req = state_r != dcl_pkg::ST_IDLE;
    assign mem_we = state_r != dcl_pkg::ST_IDLE && state_r != dcl_pkg::ST_FILL;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign mem_wmask = mem_wmask_r;
    assign icache_clear = icache_clear_r;
    assign icache_addr = icache_addr_r;

    default clocking dcl_cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    AST_FILL_VALID: assert property (
        state_r == dcl_pkg::ST_FILL && mem_ack && alloc_r |=> valid_r[fill_set_r][fill_way_r])
        else $error("filled line not valid");
    AST_WB_AFTER_FILL: assert property (
        state_r == dcl_pkg::ST_FILL && mem_ack && pbuf_full_r |=>
        state_r == dcl_pkg::ST_WB && mem_we && mem_addr == $past(pbuf_addr_r))
        else $error("victim not written after fill");
    AST_CB_HIT_MOD: assert property (
        accept && cpu_we && c_hit && !c_wt |=> mod_r[$past(c_set)][$past(c_find[1:0])] && cpu_ack)
        else $error("copyback write hit not modified");
    AST_WT_HIT_VALID: assert property (
        accept && cpu_we && c_hit && c_wt |=>
        !mod_r[$past(c_set)][$past(c_find[1:0])] && state_r == dcl_pkg::ST_WT)
        else $error("write-through hit left modified");
    AST_WT_MISS_KEEP: assert property (
        accept && cpu_we && !c_hit && c_wt |=>
        $stable(valid_r[$past(c_set)]) && $stable(mod_r[$past(c_set)]) && mem_we)
        else $error("write-through miss changed line");
    AST_READ_HIT: assert property (
        accept && !cpu_we && c_hit |=> cpu_ack && $stable(mod_r[$past(c_set)]))
        else $error("read hit changed state or no answer");
    AST_IVO_NO_WRITE: assert property (
        cpu_ready == 1'b0 && state_r == dcl_pkg::ST_IDLE && !flush_pend_r && push_pend_r &&
        ctrl_r[dcl_pkg::CTL_IVO] |=> !mem_req)
        else $error("invalidate-only push wrote memory");
    AST_NO_MISS_WHILE_BUF: assert property (
        pbuf_full_r |-> !cpu_ready)
        else $error("request taken while push buffer busy");
    AST_ACK_PULSE: assert property (
        cpu_ack |=> !cpu_ack)
        else $error("core answer longer than one cycle");
endmodule
`default_nettype wire

// [tb/dcl_mem_model.sv]
/* Behavioural line memory for the cache's memory port.
   Assumes one request at a time, held until the ack pulse. */
`timescale 1ns/1ps
`default_nettype none
module dcl_mem_model (
    input wire logic clk_sys, // Clock
    input wire logic mem_req, // Request level
    input wire logic mem_we, // Write
    input wire logic [31:0] mem_addr, // Address
    input wire logic [127:0] mem_wdata, // Line data
    input wire logic [3:0] mem_wmask, // Word enables
    output logic mem_ack, // Done pulse
    output logic [127:0] mem_rdata // Fetched line
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] a;
    logic slow = 1'b0;
    int cnt = 0;
    // Latency alternates so prompt and slow answers both occur
    always @(posedge clk_sys)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!mem_req || mem_ack)
            cnt <= 0;
        else if (cnt < (slow ? 3 : 0))
            cnt <= cnt + 1;
        else
        begin
            mem_ack <= 1'b1;
            slow <= !slow;
            for (int n = 0; n < 4; n++)
            begin
                a = {mem_addr[31:4], 4'h0} + 32'(4 * n);
                if (mem_we && mem_wmask[n])
                    mem[a] = mem_wdata[32*n+:32];
                mem_rdata[32*n+:32] <= mem.exists(a) ? mem[a] : a ^ 32'h5a5a_0000;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/dcl_line_ctrl_tb.sv]
/* Self-checking bench for the data cache line controller.
   Assumes the behavioural memory model on the memory port. */
`timescale 1ns/1ps
`default_nettype none
module dcl_line_ctrl_tb;
    localparam logic [31:0] A = 32'h0000_1040, B = 32'h0000_1840, C = 32'h0000_2050;
    logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, cpu_req = 0, cpu_we = 0;
    logic [31:0] paddr = '0, pwdata = '0, cpu_addr = '0, cpu_wdata = '0, r, e;
    logic [31:0] prdata, cpu_rdata, mem_addr, icache_addr;
    logic pready, pslverr, cpu_ready, cpu_ack, mem_req, mem_we, mem_ack, icache_clear;
    logic [127:0] mem_wdata, mem_rdata;
    logic [3:0] mem_wmask;
    int bad_count = 0, n_tests = 0, cyc = 0, n_clr = 0;
    always #2.5 clk_sys = ~clk_sys;
    dcl_line_ctrl dcl_line_ctrl_inst (.clk_sys(clk_sys), .srst(srst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_ready(cpu_ready), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_wmask(mem_wmask), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .icache_clear(icache_clear), .icache_addr(icache_addr));
    dcl_mem_model dcl_mem_model_inst (.clk_sys(clk_sys), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wmask(mem_wmask), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    task complete_run;
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        r = prdata;
        e = {31'h0, pslverr};
        psel <= 0;
        penable <= 0;
    endtask
    task core(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cpu_req <= 1;
        cpu_we <= w;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge clk_sys);
        while (cpu_ready !== 1'b1) @(posedge clk_sys);
        cpu_req <= 0;
        while (cpu_ack !== 1'b1) @(posedge clk_sys);
        r = cpu_rdata;
    endtask
    task rd(input logic [31:0] a, input logic [31:0] x);
        core(0, a, 0);
        chk("rdata", x, r);
    endtask
    // Flush is written together with the new configuration
    task fl(input logic [31:0] v);
        apb(1, dcl_pkg::OFS_CTRL, v | 32'h0100_0000);
    endtask
    always @(posedge clk_sys)
    begin
        cyc++;
        n_clr += (icache_clear === 1'b1);
        if (cyc == 20000)
        begin
            bad_count++;
            complete_run();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys);
        srst <= 0;
        apb(0, dcl_pkg::OFS_CTRL, 0);
        chk("ctrl", 32'h0, r);
        fl(32'h8000_0000);
        apb(0, dcl_pkg::OFS_CTRL, 0);
        chk("ctrl", 32'h8000_0000, r);
        apb(0, 8'h18, 0);
        chk("slverr", 32'h1, e);
        rd(A, A ^ 32'h5a5a_0000);
        rd(A, A ^ 32'h5a5a_0000);
        core(1, A, 32'h1111_1111);
        rd(A, 32'h1111_1111);
        fl(32'h8000_0000);
        rd(A, A ^ 32'h5a5a_0000);
        for (int k = 0; k < 5; k++) core(1, 32'h0004_0040 + k * 32'h800, 32'hd000_0000 + k);
        for (int k = 0; k < 5; k++) rd(32'h0004_0040 + k * 32'h800, 32'hd000_0000 + k);
        fl(32'h8000_4000);
        core(1, A, 32'h2222_2222);
        core(1, B, 32'h3333_3333);
        apb(1, dcl_pkg::OFS_PUSH, A);
        fl(32'h8000_0000);
        rd(B, B ^ 32'h5a5a_0000);
        rd(A, 32'h2222_2222);
        fl(32'h9000_1000);
        core(1, C, 32'h4444_4444);
        for (int w = 0; w < 4; w++) apb(1, dcl_pkg::OFS_PUSH_BOTH, 32'h50 + w);
        fl(32'h8000_0000);
        chk("icache_addr", 32'h53, icache_addr);
        rd(C, 32'h4444_4444);
        fl(32'h8010_4000);
        core(1, A, 32'h5555_5555);
        apb(1, dcl_pkg::OFS_PUSH_BOTH, A);
        rd(A, 32'h2222_2222);
        fl(32'h8000_0100);
        core(1, B, 32'h6666_6666);
        rd(B, 32'h6666_6666);
        core(1, B, 32'h7777_7777);
        fl(32'h8000_0100);
        rd(B, 32'h7777_7777);
        fl(32'h8000_0000);
        apb(1, dcl_pkg::OFS_REGION0, 32'h1000_8020);
        core(1, 32'h1000_0040, 32'h8888_8888);
        fl(32'h8000_0000);
        rd(32'h1000_0040, 32'h8888_8888);
        chk("icache_clear", 32'h1, n_clr);
        complete_run();
    end
endmodule
`default_nettype wire
